// [hdl/spt_pkg.sv]
// Shared constants and carrier types for the six-phase PWM trigger block.
// Assumes a 32-bit classic Wishbone bus with byte addresses on adr_i.
package spt_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [31:0] TRIG_A_OPT_IDX = 32'hFFFFF622;
    localparam logic [31:0] TRIG_B_OPT_IDX = 32'hFFFFF623;
    localparam logic [31:0] OUT_CTL_IDX = 32'hFFFFF624;

    // ----------------------------------------------------------------
    // Reset values and writable-bit masks
    // ----------------------------------------------------------------
    localparam logic [5:0] TRIG_OPT_RESET = 6'h00;
    localparam logic [7:0] OUT_CTL_RESET = 8'hA8;
    localparam logic [7:0] OUT_CTL_MASK = 8'hFC;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TRIG_OPT_WIDTH = 6;
    localparam int NUM_NEG_CH = 3;
    localparam int NEG_EN_BASE = 2;
    localparam int NEG_LVL_BASE = 3;
    localparam int NEG_CH_STRIDE = 2;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    // Layout matches option register bits 5..0
    typedef struct packed {
        logic ch1DirectionSel;
        logic ch0DirectionSel;
        logic ch1Enable;
        logic ch0Enable;
        logic crestEnable;
        logic valleyEnable;
    } spt_trig_cfg_t;

    typedef struct packed {
        logic compareCh1Event;
        logic compareCh0Event;
        logic crestEvent;
        logic valleyEvent;
    } spt_events_t;

    // Word-aligned address match against a register index
    function automatic logic spt_adr_hit(input logic [31:0] adr, input logic [31:0] idx);
        return adr[31:2] == idx[29:0];
    endfunction

endpackage

// [hdl/spt_trig_route.sv]
// Routes timer events onto one converter trigger output.
// Assumes events are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module spt_trig_route
    import spt_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire spt_trig_cfg_t cfg,
    input wire spt_events_t timerEvents,
    input wire logic deadCountDown,
    output logic trigPulse
);

    // ----------------------------------------------------------------
    // Source qualification
    // ----------------------------------------------------------------
    // Compare events gated by enable and dead-time direction
    wire logic ch1Hit = timerEvents.compareCh1Event & cfg.ch1Enable
        & (cfg.ch1DirectionSel == deadCountDown); // R1
    wire logic ch0Hit = timerEvents.compareCh0Event & cfg.ch0Enable
        & (cfg.ch0DirectionSel == deadCountDown); // R2
    wire logic crestHit = timerEvents.crestEvent & cfg.crestEnable; // R3
    wire logic valleyHit = timerEvents.valleyEvent & cfg.valleyEnable; // R4
    wire logic anyHit = ch1Hit | ch0Hit | crestHit | valleyHit; // R18
    wire logic noSource = ~(cfg.ch1Enable | cfg.ch0Enable | cfg.crestEnable | cfg.valleyEnable);
    wire logic onlyCh1 = timerEvents == 4'h8;

    // Single-cycle trigger pulse per qualifying event
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trigPulse <= 1'b0;
        end else begin
            trigPulse <= anyHit; // R18
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    trig_has_cause_a: assert property (trigPulse |-> $past(timerEvents) != 4'h0) // R18
        else $error("trigger without any event");
    no_source_quiet_a: assert property (noSource |=> !trigPulse) // R4
        else $error("trigger with every source disabled");
    direction_gate_a: assert property (
        (onlyCh1 && cfg.ch1Enable && cfg.ch1DirectionSel != deadCountDown) |=> !trigPulse) // R1
        else $error("compare trigger in wrong counting direction");

endmodule
`default_nettype wire

// [hdl/spt_neg_pin.sv]
// One negative-side PWM pin: fixed level or phased waveform.
// Assumes phaseWave is the channel's positive-phase drive from the dead-time logic.
`timescale 1ns/1ps
`default_nettype none
module spt_neg_pin
    import spt_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic levelSel,
    input wire logic outEnable,
    input wire logic timerRunEnable,
    input wire logic phaseWave,
    output logic pinLevel
);

    // ----------------------------------------------------------------
    // Pin selection
    // ----------------------------------------------------------------
    // Waveform only while enabled and running; level 1 inverts phase
    wire logic passWave = outEnable & timerRunEnable; // R17
    wire logic phasedWave = phaseWave ^ levelSel;
    wire logic pinNext = passWave ? phasedWave : levelSel; // R16

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinLevel <= RESET_LEVEL;
        end else begin
            pinLevel <= pinNext;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    pin_fixed_level_a: assert property (!passWave |=> pinLevel == $past(levelSel)) // R17
        else $error("idle pin not at its level bit");
    pin_wave_phase_a: assert property (passWave |=> pinLevel == $past(phasedWave)) // R17
        else $error("running pin has wrong phase");

endmodule
`default_nettype wire

// [hdl/spt_ctrl.sv]
// Top of the six-phase PWM option logic: registers, two converter
// triggers and three negative-side pins.
// Assumes a classic Wishbone master and event pulses from the timer core.
//
// Overview of operation
// R1: Trigger A compare needs matching count direction
// R2: Trigger A compare sources need enable bits
// R3: Trigger A crest source follows its enable
// R4: Trigger A valley blocked when disabled
// R5: Option register B: 8 bits, reset zero
// R6: Option register B layout, top bits zero
// R7: Trigger B compare needs matching count direction
// R8: Trigger B compare sources need enable bits
// R9: Trigger B crest source follows bit 1
// R10: Trigger B valley source follows bit 0
// R11: Output control: 8 bits, reset A8H
// R12: Software changes output control only when stopped
// R13: Same-value write while running changes nothing
// R14: Software enables positive pin before output control
// R15: Software keeps A8H outside six-phase mode
// R16: Negative pins use level and enable bits
// R17: Negative pin level, or phased wave when running
// R18: One-cycle pulse per enabled event, ORed
// R19: Reserved bits read zero, ignore writes
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module spt_ctrl
    import spt_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire spt_events_t timerEvents,
    input wire logic deadCountDown,
    input wire logic timerRunEnable,
    input wire logic [NUM_NEG_CH-1:0] negPhaseWave,
    output logic converterTriggerA,
    output logic converterTriggerB,
    output logic [NUM_NEG_CH-1:0] negSidePwmPin
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [5:0] trigAOpt_q;
    logic [5:0] trigAOpt_d;
    logic [5:0] trigBOpt_q;
    logic [5:0] trigBOpt_d;
    logic [7:0] outCtl_q;
    logic [7:0] outCtl_d;
    logic [31:0] readData_d;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One access per request; ack is a single-cycle answer
    wire logic busReq = cyc_i & stb_i & ~ack_o;
    wire logic busWrite = busReq & we_i & sel_i[0];
    wire logic hitA = spt_adr_hit(adr_i, TRIG_A_OPT_IDX);
    wire logic hitB = spt_adr_hit(adr_i, TRIG_B_OPT_IDX);
    wire logic hitOut = spt_adr_hit(adr_i, OUT_CTL_IDX);
    wire logic [7:0] wrByte = dat_i[7:0];

    // Write strobes; output control locked while the timer runs
    wire logic wrA = busWrite & hitA;
    wire logic wrB = busWrite & hitB; // R5
    wire logic wrOutRaw = busWrite & hitOut;
    wire logic wrOut = wrOutRaw & ~timerRunEnable; // R13

    // Next register values; reserved bits dropped
    assign trigAOpt_d = wrA ? wrByte[5:0] : trigAOpt_q;
    assign trigBOpt_d = wrB ? wrByte[5:0] : trigBOpt_q; // R6
    assign outCtl_d = wrOut ? (wrByte & OUT_CTL_MASK) : outCtl_q; // R19

    // Read data, reserved and unmapped bits read zero
    assign readData_d = hitA ? 32'({2'b00, trigAOpt_q})
        : hitB ? 32'({2'b00, trigBOpt_q}) // R6
        : hitOut ? 32'(outCtl_q)
        : 32'h0000_0000; // R19

    // ----------------------------------------------------------------
    // Register update
    // ----------------------------------------------------------------
    // Option and output-control registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trigAOpt_q <= TRIG_OPT_RESET;
            trigBOpt_q <= TRIG_OPT_RESET; // R5
            outCtl_q <= OUT_CTL_RESET; // R11
        end else begin
            trigAOpt_q <= trigAOpt_d;
            trigBOpt_q <= trigBOpt_d;
            outCtl_q <= outCtl_d;
        end
    end

    // Bus answer: ack and read data one cycle after the request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= busReq;
            dat_o <= busReq ? readData_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Converter triggers
    // ----------------------------------------------------------------
    // Trigger A from the first option register
    spt_trig_route u_trig_a (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .cfg(spt_trig_cfg_t'(trigAOpt_q)), // R1 R2 R3 R4
        .timerEvents(timerEvents),
        .deadCountDown(deadCountDown),
        .trigPulse(converterTriggerA)
    );

    // Trigger B from the second option register
    spt_trig_route u_trig_b (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .cfg(spt_trig_cfg_t'(trigBOpt_q)), // R7 R8 R9 R10
        .timerEvents(timerEvents),
        .deadCountDown(deadCountDown),
        .trigPulse(converterTriggerB)
    );

    // ----------------------------------------------------------------
    // Negative-side pins
    // ----------------------------------------------------------------
    // Channel m uses enable bit 2m+2 and level bit 2m+3
    for (genvar ch = 0; ch < NUM_NEG_CH; ch++) begin : g_neg
        spt_neg_pin #(
            .RESET_LEVEL(OUT_CTL_RESET[NEG_LVL_BASE + NEG_CH_STRIDE * ch])
        ) u_pin (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .levelSel(outCtl_q[NEG_LVL_BASE + NEG_CH_STRIDE * ch]), // R16
            .outEnable(outCtl_q[NEG_EN_BASE + NEG_CH_STRIDE * ch]), // R16
            .timerRunEnable(timerRunEnable),
            .phaseWave(negPhaseWave[ch]),
            .pinLevel(negSidePwmPin[ch])
        );
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Helpers for the checks
    wire logic onlyValley = timerEvents == 4'h1;
    wire logic onlyCrest = timerEvents == 4'h2;

    bus_ack_next_a: assert property (busReq |=> ack_o)
        else $error("bus request not answered next cycle");
    bus_ack_drop_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ctl_lock_run_a: assert property ((wrOutRaw && timerRunEnable) |=> $stable(outCtl_q)) // R13
        else $error("output control changed while running");
    opt_b_write_a: assert property (wrB |=> trigBOpt_q == $past(wrByte[5:0])) // R5
        else $error("option register B did not take the write");
    ctl_write_stop_a: assert property ((wrOutRaw && !timerRunEnable)
        |=> outCtl_q == ($past(wrByte) & OUT_CTL_MASK)) // R11
        else $error("output control did not take the write");
    read_upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000) // R19
        else $error("upper read data not zero");
    ctl_reserved_a: assert property (outCtl_q[1:0] == 2'b00) // R19
        else $error("reserved output control bits set");
    crest_b_gate_a: assert property ((onlyCrest && !trigBOpt_q[1]) |=> !converterTriggerB) // R9
        else $error("crest trigger B while disabled");
    valley_b_pass_a: assert property ((onlyValley && trigBOpt_q[0]) |=> converterTriggerB) // R10
        else $error("valley trigger B missing");

    trig_a_seen_c: cover property (converterTriggerA && converterTriggerB);
    lock_write_c: cover property (wrOutRaw && timerRunEnable);
    pin_running_c: cover property (timerRunEnable && outCtl_q[NEG_EN_BASE] ##1 negSidePwmPin[0]);

endmodule
`default_nettype wire

// [verif/spt_far_model.sv]
// Far-side sink model: converter trigger inputs of the A/D converter.
// Assumes trigger pulses are synchronous to core_clk, one cycle each.
`timescale 1ns/1ps
`default_nettype none
module spt_far_model
    import spt_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic trigA,
    input wire logic trigB,
    output int trigCountA,
    output int trigCountB
);
    // Count conversion starts, one per high cycle
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trigCountA <= 0;
            trigCountB <= 0;
        end else begin
            trigCountA <= trigCountA + int'(trigA === 1'b1);
            trigCountB <= trigCountB + int'(trigB === 1'b1);
        end
    end
endmodule
`default_nettype wire

// [verif/tb_spt_ctrl.sv]
// Self-checking bench for the six-phase PWM option logic top.
// Assumes one 200 MHz clock and the far-side sink model.
`timescale 1ns/1ps
`default_nettype none
module tb_spt_ctrl;
    import spt_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [31:0] adr = 32'h00000000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    spt_events_t ev = 4'h0;
    logic down = 1'b0;
    logic run = 1'b0;
    logic [2:0] wave = 3'h0;
    logic trigA;
    logic trigB;
    logic [2:0] pins;
    int cntA;
    int cntB;
    int expA = 0;
    int expB = 0;
    int badCount = 0;
    int cmpCount = 0;
    logic [31:0] lfsr = 32'h595B;
    logic [31:0] readQ[$];
    logic [1:0] trigQ[$];
    logic [1:0] tq;
    logic evtSeen = 1'b0;

    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    spt_ctrl dut_u (.core_clk(core_clk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .timerEvents(ev), .deadCountDown(down), .timerRunEnable(run),
        .negPhaseWave(wave), .converterTriggerA(trigA), .converterTriggerB(trigB),
        .negSidePwmPin(pins));
    spt_far_model far_u (.core_clk(core_clk), .arst_n(arst_n), .trigA(trigA),
        .trigB(trigB), .trigCountA(cntA), .trigCountB(cntB));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ba(input logic [31:0] idx);
        return {idx[29:0], 2'b00};
    endfunction
    function automatic logic trg(input logic [5:0] c, input logic [3:0] e, input logic d);
        return (e[3] & c[3] & (c[5] == d)) | (e[2] & c[2] & (c[4] == d)) | (e[1] & c[1])
            | (e[0] & c[0]);
    endfunction
    function automatic logic [2:0] pinExp(input logic [7:0] oc, input logic r,
        input logic [2:0] w);
        logic [2:0] p;
        for (int m = 0; m < NUM_NEG_CH; m++) begin
            p[m] = oc[NEG_LVL_BASE + NEG_CH_STRIDE * m];
            if (oc[NEG_EN_BASE + NEG_CH_STRIDE * m] && r) begin
                p[m] = p[m] ^ w[m];
            end
        end
        return p;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finishTest();
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic wbCycle(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) check("ack", 32'h00000000, 32'h00000001);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        wbCycle(1'b1, a, {24'h000000, d}, 4'hF);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        readQ.push_back({24'h000000, e});
        wbCycle(1'b0, a, 32'h00000000, 4'hF);
    endtask
    // Random events and direction, expected triggers noted
    task automatic fire(input logic [5:0] ca, input logic [5:0] cb);
        lfsr = nextRnd(lfsr);
        @(posedge core_clk);
        ev <= lfsr[3:0];
        down <= lfsr[4];
        if (lfsr[3:0] != 4'h0) begin
            trigQ.push_back({trg(cb, lfsr[3:0], lfsr[4]), trg(ca, lfsr[3:0], lfsr[4])});
            expA += int'(trg(ca, lfsr[3:0], lfsr[4]));
            expB += int'(trg(cb, lfsr[3:0], lfsr[4]));
        end
    endtask

    // ------------------------------------------------------------
    // Output watcher: oldest note against each result
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            check("read", rdat, readQ.pop_front());
        end
        if (evtSeen) begin
            tq = trigQ.pop_front();
            check("trigA", 32'(trigA), 32'(tq[0]));
            check("trigB", 32'(trigB), 32'(tq[1]));
        end
        evtSeen <= (ev != 4'h0);
    end

    // Watchdog
    initial begin
        #100000;
        badCount++;
        finishTest();
    end

    // Main sequence
    initial begin
        logic [5:0] ca;
        logic [5:0] cb;
        logic [7:0] oc;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(ba(TRIG_A_OPT_IDX), 8'h00);
        rd(ba(TRIG_B_OPT_IDX), 8'h00);
        rd(ba(OUT_CTL_IDX), 8'hA8);
        check("pinsReset", 32'(pins), 32'h00000007);
        wr(ba(TRIG_B_OPT_IDX), 8'hFF);
        rd(ba(TRIG_B_OPT_IDX), 8'h3F);
        wbCycle(1'b1, ba(TRIG_B_OPT_IDX), 32'h00000000, 4'hE);
        rd(ba(TRIG_B_OPT_IDX), 8'h3F);
        wr(32'h00000010, 8'h55);
        rd(32'h00000010, 8'h00);
        for (int i = 0; i < 40; i++) begin
            lfsr = nextRnd(lfsr);
            ca = lfsr[5:0];
            cb = lfsr[13:8];
            wr(ba(TRIG_A_OPT_IDX), {2'b11, ca});
            wr(ba(TRIG_B_OPT_IDX), {2'b11, cb});
            repeat (6) fire(ca, cb);
            @(posedge core_clk);
            ev <= 4'h0;
        end
        for (int i = 0; i < 8; i++) begin
            lfsr = nextRnd(lfsr);
            oc = lfsr[7:0] & OUT_CTL_MASK;
            run <= 1'b0;
            wr(ba(OUT_CTL_IDX), lfsr[7:0]);
            rd(ba(OUT_CTL_IDX), oc);
            check("pinsStop", 32'(pins), 32'(pinExp(oc, 1'b0, wave)));
            run <= 1'b1;
            wave <= lfsr[18:16];
            repeat (2) @(posedge core_clk);
            check("pinsRun", 32'(pins), 32'(pinExp(oc, 1'b1, lfsr[18:16])));
            wr(ba(OUT_CTL_IDX), ~oc);
            wr(ba(OUT_CTL_IDX), oc);
            rd(ba(OUT_CTL_IDX), oc);
            // Option register B stays writable while the timer runs
            wr(ba(TRIG_B_OPT_IDX), lfsr[15:8]);
            rd(ba(TRIG_B_OPT_IDX), {2'b00, lfsr[13:8]});
        end
        run <= 1'b0;
        wr(ba(OUT_CTL_IDX), 8'hA8);
        repeat (4) @(posedge core_clk);
        check("cntA", cntA, expA);
        check("cntB", cntB, expB);
        finishTest();
    end
endmodule
`default_nettype wire
